// [rtl/rcs_pkg.sv]
// Purpose: Shared constants and carriers for the reset cause and start-up sequencer
// Assumes: 125 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are word indices; byte address is four times the index
package rcs_pkg;

  // Register word indices; byte address is index * 4
  localparam logic [11:0] IDX_PWR_CTRL = 12'h08e;
  localparam logic [11:0] IDX_CONFIG = 12'h08f;
  localparam logic [11:0] IDX_STATUS = 12'h090;

  // Power-control register layout
  localparam int RESET_CAUSE_POWER_CONTROL_POR_BIT = 1;
  localparam int RESET_CAUSE_POWER_CONTROL_BOR_BIT = 0;

  // Configuration register layout and values after reset
  localparam int CFG_BROWNOUT_DETECT_ENABLE_BIT = 8;
  localparam int CFG_PINSEL_BIT = 5;
  localparam int CFG_DLYDIS_BIT = 4;
  localparam logic CFG_BROWNOUT_DETECT_ENABLE_RST = 1'b1;
  localparam logic CFG_PINSEL_RST = 1'b1;
  localparam logic CFG_DLYDIS_RST = 1'b1;

  // Status register layout
  localparam int STAT_TO_BIT = 4;
  localparam int STAT_PD_BIT = 3;
  localparam int STAT_PIN_BIT = 1;
  localparam int STAT_HELD_BIT = 0;

  // Flag values after the very first reset
  localparam logic POR_FLAG_RST = 1'b0;
  localparam logic BOR_FLAG_RST = 1'b1;
  localparam logic TO_FLAG_RST = 1'b1;
  localparam logic PD_FLAG_RST = 1'b1;

  // Timing
  localparam longint CLK_HZ = 64'd125000000;
  localparam longint BOR_FILTER_US = 64'd100;
  localparam longint STARTUP_DELAY_MS = 64'd64;
  localparam longint BOR_FILTER_CYC = (BOR_FILTER_US * CLK_HZ + 64'd999999) / 64'd1000000;
  localparam longint STARTUP_DELAY_CYC = (STARTUP_DELAY_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam int RC_DIV = 4;
  localparam int STARTUP_DELAY_TICKS = int'((STARTUP_DELAY_CYC + RC_DIV - 1) / RC_DIV);
  localparam int OST_CYC = 1024;
  localparam int PIN_FILTER_CYC = 16;
  localparam int CNT_W = 24;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {SEL_NONE, SEL_PWR, SEL_CFG, SEL_STAT} rcs_sel_e;

  typedef enum logic [2:0] {ST_HOLD, ST_DELAY, ST_OST, ST_PINWAIT, ST_RUN} rcs_state_e;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } rcs_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rcs_axi_rsp_s;

endpackage

// [rtl/rcs_sequencer.sv]
// Purpose: Reset source merge, start-up sequencing and reset cause flags
// Assumes: All inputs synchronous to clk; rst_n is the cold power-up reset
// Notes: Notes on behaviour list below; config register survives core resets
//
// Notes on behaviour
// - Reset enters from power-on, overheat, pin, watchdog expiry or brownout.
// - After power-on the startup delay may lengthen reset if enabled.
// - Ordinary logic resets on core reset; exempt state only on cold reset.
// - Watchdog wake from sleep resumes operation without any reset.
// - Flags: POR 0/1/1, BOR 0/1/1, watchdog reset TO 0, wake TO/PD 0.
// - Pin reset while running keeps flags; during sleep sets TO 1, PD 0.
// - External pin low pulses shorter than the filter are ignored.
// - Watchdog reset is internal only and never drives the pin low.
// - Pin select 0 means internal reset; 1 makes pin an input with pull-up.
// - Brownout detection follows the enable at configuration bit 8.
// - Brownout declared only after supply stays low for over 100 us.
// - After any reset hold until supply is above brownout threshold.
// - Enabled startup delay adds 64 ms once supply and overheat release, before the oscillator timer.
// - Supply dip during startup delay re-enters reset and restarts delay.
// - With brownout off or sleeping, only the power-on detector starts a supply reset.
// - Startup delay disable bit set turns delay off, cleared turns it on.
// - Startup delay runs after power-up or brownout, paced by slow oscillator tick.
// - Run needs delay done, oscillator timer done and pin released.
// - Timeouts run from power-on; late pin release starts run at once.
// - Power-control register sits at index 8Eh holding two cause flags.
// - Watchdog expiry while awake resets the core and records it in TO; PD keeps its value.
// - POR flag bit 1, BOR flag bit 0; hardware clears, software sets.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps

module rcs_sequencer #(
  parameter int BOR_FILTER_CYC = int'(rcs_pkg::BOR_FILTER_CYC),
  parameter int STARTUP_TICKS = rcs_pkg::STARTUP_DELAY_TICKS
) (
  input wire logic clk, // Core clock, 125 MHz
  input wire logic rst_n, // Cold reset, synchronous
  input wire rcs_pkg::rcs_axi_req_s axi_req, // AXI4-Lite master side
  output rcs_pkg::rcs_axi_rsp_s axi_rsp, // AXI4-Lite slave side
  input wire logic supply_above_por, // Supply over power-on threshold
  input wire logic supply_above_bor, // Supply over brownout threshold
  input wire logic overheat_reset, // Overtemperature request, level
  input wire logic ext_rst_pin_i, // External reset pin level
  output logic ext_rst_pin_o, // Pin output value, always low
  output logic ext_rst_pin_oe_n, // Pin drive enable, active low
  output logic ext_rst_pullup_en, // Weak pull-up on the pin
  input wire logic watchdog_expire, // Watchdog timeout, pulse
  input wire logic watchdog_clear_instruction, // Clear executed, pulse
  input wire logic sleep_instruction, // Sleep executed, pulse
  input wire logic sleeping, // Core is asleep
  output logic core_rst_n, // Core reset, active low
  output logic wake_pulse // Watchdog wake from sleep
);

  localparam int CW = rcs_pkg::CNT_W;

  function automatic rcs_pkg::rcs_sel_e reg_sel(input logic [11:0] addr);
    if (addr[1:0] != 2'b00)
      return rcs_pkg::SEL_NONE;
    else if (addr[11:2] == rcs_pkg::IDX_PWR_CTRL[9:0])
      return rcs_pkg::SEL_PWR;
    else if (addr[11:2] == rcs_pkg::IDX_CONFIG[9:0])
      return rcs_pkg::SEL_CFG;
    else if (addr[11:2] == rcs_pkg::IDX_STATUS[9:0])
      return rcs_pkg::SEL_STAT;
    else
      return rcs_pkg::SEL_NONE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  rcs_pkg::rcs_state_e state_q;
  rcs_pkg::rcs_state_e state_d;
  logic bor_en_q;
  logic pin_sel_q;
  logic dly_dis_q;
  logic por_flag_q;
  logic bor_flag_q;
  logic to_flag_q;
  logic pd_flag_q;
  logic por_low_q;
  logic timer_cause_q;
  logic pin_asserted_q;
  logic [CW-1:0] bor_cnt_q;
  logic [CW-1:0] pin_cnt_q;
  logic [CW-1:0] tcnt_q;
  logic [$clog2(rcs_pkg::RC_DIV)-1:0] rc_div_q;
  logic rc_tick;
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_write;
  logic wr_pwr;
  logic wr_cfg;
  logic ar_fire;
  logic por_low;
  logic bor_active;
  logic supply_bad;
  logic hold_cond;
  logic por_evt;
  logic bor_evt;
  logic pin_low_raw;
  logic pin_evt;
  logic running;
  logic wdt_rst_evt;
  logic wdt_wake_evt;
  logic pin_sleep_evt;
  logic delay_done;
  logic ost_done;

  ////////////////////////////////////////////////////////////////////////////
  // Source detection

  assign por_low = !supply_above_por;
  assign por_evt = por_low && !por_low_q;
  // Brownout monitor is blind in sleep; the power-on detector covers that case
  assign bor_active = bor_en_q && !sleeping;
  assign bor_evt = bor_active && !supply_above_bor &&
                   bor_cnt_q == CW'(BOR_FILTER_CYC - 1);
  assign supply_bad = por_low || !supply_above_bor;
  assign hold_cond = supply_bad || overheat_reset;
  assign pin_low_raw = pin_sel_q && !ext_rst_pin_i;
  assign pin_evt = pin_low_raw && !pin_asserted_q &&
                   pin_cnt_q == CW'(rcs_pkg::PIN_FILTER_CYC - 1);
  assign running = state_q == rcs_pkg::ST_RUN;
  assign wdt_rst_evt = watchdog_expire && running && !sleeping;
  assign wdt_wake_evt = watchdog_expire && running && sleeping;
  assign pin_sleep_evt = pin_evt && running && sleeping;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      por_low_q <= 1'b0;
    else
      por_low_q <= por_low;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bor_cnt_q <= '0;
    else if (!bor_active || supply_above_bor)
      bor_cnt_q <= '0;
    else if (bor_cnt_q != CW'(BOR_FILTER_CYC))
      bor_cnt_q <= bor_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_cnt_q <= '0;
      pin_asserted_q <= 1'b0;
    end
    else if (!pin_low_raw)
    begin
      pin_cnt_q <= '0;
      pin_asserted_q <= 1'b0;
    end
    else
    begin
      if (pin_cnt_q != CW'(rcs_pkg::PIN_FILTER_CYC))
        pin_cnt_q <= pin_cnt_q + 1'b1;
      if (pin_evt)
        pin_asserted_q <= 1'b1;
    end
  end

  // Slow oscillator stand-in: the delay advances on a divided tick
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rc_div_q <= '0;
    else if (rc_div_q == ($clog2(rcs_pkg::RC_DIV))'(rcs_pkg::RC_DIV - 1))
      rc_div_q <= '0;
    else
      rc_div_q <= rc_div_q + 1'b1;
  end
  assign rc_tick = rc_div_q == ($clog2(rcs_pkg::RC_DIV))'(rcs_pkg::RC_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Release sequencer

  assign delay_done = rc_tick && tcnt_q == CW'(STARTUP_TICKS - 1);
  assign ost_done = tcnt_q == CW'(rcs_pkg::OST_CYC - 1);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      rcs_pkg::ST_HOLD:
        if (!hold_cond)
        begin
          if (!timer_cause_q)
            state_d = rcs_pkg::ST_PINWAIT;
          else if (!dly_dis_q)
            state_d = rcs_pkg::ST_DELAY;
          else
            state_d = rcs_pkg::ST_OST;
        end
      rcs_pkg::ST_DELAY:
        if (hold_cond)
          state_d = rcs_pkg::ST_HOLD;
        else if (delay_done)
          state_d = rcs_pkg::ST_OST;
      rcs_pkg::ST_OST:
        if (hold_cond)
          state_d = rcs_pkg::ST_HOLD;
        else if (ost_done)
          state_d = rcs_pkg::ST_PINWAIT;
      rcs_pkg::ST_PINWAIT:
        if (hold_cond)
          state_d = rcs_pkg::ST_HOLD;
        else if (!pin_asserted_q)
          state_d = rcs_pkg::ST_RUN;
      // A running core ignores short brownout dips; of the supply events only the filtered brownout or a power-on drop stops it
      rcs_pkg::ST_RUN:
        if (por_low || overheat_reset || bor_evt || pin_asserted_q || pin_evt || wdt_rst_evt)
          state_d = rcs_pkg::ST_HOLD;
      default:
        state_d = rcs_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= rcs_pkg::ST_HOLD;
    else
      state_q <= state_d;
  end

  // Timers count from the release of the hold state, whatever the pin does meanwhile
  always_ff @(posedge clk)
  begin
    if (!rst_n || state_d != state_q)
      tcnt_q <= '0;
    else if (state_q == rcs_pkg::ST_OST || (state_q == rcs_pkg::ST_DELAY && rc_tick))
      tcnt_q <= tcnt_q + 1'b1;
  end

  // Only power loss arms the long timers; warm resets skip them
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      timer_cause_q <= 1'b1;
    else if (por_evt || bor_evt || (supply_bad && !running))
      timer_cause_q <= 1'b1;
    else if (state_q == rcs_pkg::ST_PINWAIT)
      timer_cause_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      core_rst_n <= 1'b0;
      wake_pulse <= 1'b0;
    end
    else
    begin
      core_rst_n <= state_d == rcs_pkg::ST_RUN;
      wake_pulse <= wdt_wake_evt;
    end
  end

  assign ext_rst_pin_o = 1'b0;
  assign ext_rst_pin_oe_n = 1'b1;
  assign ext_rst_pullup_en = pin_sel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags; hardware events win over a same-cycle software write

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      por_flag_q <= rcs_pkg::POR_FLAG_RST;
      bor_flag_q <= rcs_pkg::BOR_FLAG_RST;
    end
    else
    begin
      if (por_evt)
        por_flag_q <= 1'b0;
      else if (wr_pwr && wstrb_q[0])
        por_flag_q <= wdata_q[rcs_pkg::RESET_CAUSE_POWER_CONTROL_POR_BIT];
      if (bor_evt)
        bor_flag_q <= 1'b0;
      else if (wr_pwr && wstrb_q[0])
        bor_flag_q <= wdata_q[rcs_pkg::RESET_CAUSE_POWER_CONTROL_BOR_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      to_flag_q <= rcs_pkg::TO_FLAG_RST;
      pd_flag_q <= rcs_pkg::PD_FLAG_RST;
    end
    else if (por_evt || bor_evt)
    begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end
    else if (wdt_rst_evt)
      to_flag_q <= 1'b0;
    else if (wdt_wake_evt)
    begin
      to_flag_q <= 1'b0;
      pd_flag_q <= 1'b0;
    end
    else if (pin_sleep_evt)
    begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b0;
    end
    else if (watchdog_clear_instruction && running)
    begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end
    else if (sleep_instruction && running)
    begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign wr_pwr = do_write && reg_sel(awaddr_q) == rcs_pkg::SEL_PWR;
  assign wr_cfg = do_write && reg_sel(awaddr_q) == rcs_pkg::SEL_CFG;
  assign ar_fire = axi_req.arvalid && !rvalid_q;

  always_comb
  begin
    axi_rsp.awready = !aw_have_q;
    axi_rsp.wready = !w_have_q;
    axi_rsp.bvalid = bvalid_q;
    axi_rsp.bresp = bresp_q;
    axi_rsp.arready = !rvalid_q;
    axi_rsp.rvalid = rvalid_q;
    axi_rsp.rdata = rdata_q;
    axi_rsp.rresp = rresp_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= rcs_pkg::RESP_OKAY;
    end
    else
    begin
      if (axi_req.awvalid && !aw_have_q)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= axi_req.awaddr;
      end
      if (axi_req.wvalid && !w_have_q)
      begin
        w_have_q <= 1'b1;
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= reg_sel(awaddr_q) == rcs_pkg::SEL_PWR ||
                   reg_sel(awaddr_q) == rcs_pkg::SEL_CFG ? rcs_pkg::RESP_OKAY
                                                         : rcs_pkg::RESP_SLVERR;
      end
      else if (bvalid_q && axi_req.bready)
      begin
        bvalid_q <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
    end
  end

  // Configuration is exempt from core resets; only the cold reset loads it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bor_en_q <= rcs_pkg::CFG_BROWNOUT_DETECT_ENABLE_RST;
      pin_sel_q <= rcs_pkg::CFG_PINSEL_RST;
      dly_dis_q <= rcs_pkg::CFG_DLYDIS_RST;
    end
    else if (wr_cfg)
    begin
      if (wstrb_q[1])
        bor_en_q <= wdata_q[rcs_pkg::CFG_BROWNOUT_DETECT_ENABLE_BIT];
      if (wstrb_q[0])
      begin
        pin_sel_q <= wdata_q[rcs_pkg::CFG_PINSEL_BIT];
        dly_dis_q <= wdata_q[rcs_pkg::CFG_DLYDIS_BIT];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= rcs_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= '0;
      rresp_q <= rcs_pkg::RESP_OKAY;
      case (reg_sel(axi_req.araddr))
        rcs_pkg::SEL_PWR:
        begin
          rdata_q[rcs_pkg::RESET_CAUSE_POWER_CONTROL_POR_BIT] <= por_flag_q;
          rdata_q[rcs_pkg::RESET_CAUSE_POWER_CONTROL_BOR_BIT] <= bor_flag_q;
        end
        rcs_pkg::SEL_CFG:
        begin
          rdata_q[rcs_pkg::CFG_BROWNOUT_DETECT_ENABLE_BIT] <= bor_en_q;
          rdata_q[rcs_pkg::CFG_PINSEL_BIT] <= pin_sel_q;
          rdata_q[rcs_pkg::CFG_DLYDIS_BIT] <= dly_dis_q;
        end
        rcs_pkg::SEL_STAT:
        begin
          rdata_q[rcs_pkg::STAT_TO_BIT] <= to_flag_q;
          rdata_q[rcs_pkg::STAT_PD_BIT] <= pd_flag_q;
          rdata_q[rcs_pkg::STAT_PIN_BIT] <= pin_asserted_q;
          rdata_q[rcs_pkg::STAT_HELD_BIT] <= !running;
        end
        default:
          rresp_q <= rcs_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && axi_req.rready)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  pin_never_driven_a: assert property (@(posedge clk) disable iff (!rst_n)
    ext_rst_pin_oe_n && !(watchdog_expire && !ext_rst_pin_oe_n))
    else $error("Reset pin driven");

  por_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    por_evt |=> !por_flag_q && to_flag_q && pd_flag_q && !core_rst_n)
    else $error("Power-on flags wrong");

  bor_flags_a: assert property (@(posedge clk) disable iff (!rst_n)
    bor_evt |=> !bor_flag_q && to_flag_q && pd_flag_q)
    else $error("Brownout flags wrong");

  wdt_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_rst_evt |=> !to_flag_q && $stable(pd_flag_q) && !core_rst_n)
    else $error("Watchdog reset handling wrong");

  wdt_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    wdt_wake_evt && !hold_cond && !pin_evt |=> !to_flag_q && !pd_flag_q && core_rst_n
      && wake_pulse)
    else $error("Watchdog wake handling wrong");

  pin_sleep_a: assert property (@(posedge clk) disable iff (!rst_n)
    pin_sleep_evt && !por_evt && !bor_evt |=> to_flag_q && !pd_flag_q)
    else $error("Pin reset in sleep flags wrong");

  supply_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !supply_above_bor && (!running || bor_evt) |=> !core_rst_n ##1 !core_rst_n)
    else $error("Released below brownout threshold");

  delay_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == rcs_pkg::ST_DELAY && !hold_cond && delay_done
      |=> state_q == rcs_pkg::ST_OST && tcnt_q == '0)
    else $error("Startup delay end wrong");

  bor_filter_a: assert property (@(posedge clk) disable iff (!rst_n)
    bor_evt |-> $past(!supply_above_bor) && bor_cnt_q == CW'(BOR_FILTER_CYC - 1))
    else $error("Brownout declared too early");

  pin_filter_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pin_asserted_q) |-> $past(pin_low_raw, 1) && $past(pin_cnt_q) ==
      CW'(rcs_pkg::PIN_FILTER_CYC - 1))
    else $error("Pin pulse not filtered");

  release_cv: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == rcs_pkg::ST_DELAY ##[1:300] state_q == rcs_pkg::ST_OST);
  bor_cv: cover property (@(posedge clk) disable iff (!rst_n) bor_evt);
  wake_cv: cover property (@(posedge clk) disable iff (!rst_n) wdt_wake_evt);
  pin_late_cv: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == rcs_pkg::ST_PINWAIT && pin_asserted_q ##1 !pin_asserted_q);

endmodule

// [test/rcs_far_side.sv]
// Purpose: Far-side model of supply monitors, reset pin and watchdog
// Assumes: Bench calls the tasks just after a rising clock edge
// Notes: Pin is resolved here from device drive, pull-up and request
`timescale 1ns/100ps
module rcs_far_side (
  input wire logic clk, // Core clock
  input wire logic pin_o, // Pin value from device
  input wire logic pin_oe_n, // Pin drive enable, active low
  input wire logic pullup_en, // Weak pull-up on
  output logic pin, // Resolved pin level
  output logic por_ok, // Supply over power-on threshold
  output logic bor_ok, // Supply over brownout threshold
  output logic wdt // Watchdog expiry pulse
);
  logic pin_low_q;
  logic alt_q = 1'b0;
  initial
  begin
    pin_low_q = 1'b0;
    por_ok = 1'b1;
    bor_ok = 1'b1;
    wdt = 1'b0;
  end
  always_ff @(posedge clk)
    alt_q <= !alt_q;
  // Floating pin without pull-up toggles so no settled value hides a fault
  assign pin = !pin_oe_n ? pin_o : pin_low_q ? 1'b0 : pullup_en ? 1'b1 : alt_q;
  task automatic pin_pulse(input int n);
    @(posedge clk);
    pin_low_q <= 1'b1;
    repeat (n) @(posedge clk);
    pin_low_q <= 1'b0;
  endtask
  task automatic dip(input bit por, input int n);
    @(posedge clk);
    bor_ok <= 1'b0;
    if (por)
      por_ok <= 1'b0;
    repeat (n) @(posedge clk);
    bor_ok <= 1'b1;
    por_ok <= 1'b1;
  endtask
  task automatic expire;
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
  endtask
endmodule

// [test/test_reset_cause_and_startup_sequencer.sv]
// Purpose: Self-checking bench for the reset cause and start-up sequencer
// Assumes: Brownout filter 8 cycles, startup delay 4 ticks
// Notes: Far side is rcs_far_side; bus tasks start on a fresh edge
`timescale 1ns/100ps
module test_reset_cause_and_startup_sequencer;
  localparam logic [11:0] A_PWR = rcs_pkg::IDX_PWR_CTRL << 2;
  localparam logic [11:0] A_CFG = rcs_pkg::IDX_CONFIG << 2;
  localparam logic [11:0] A_ST = rcs_pkg::IDX_STATUS << 2;
  localparam logic [31:0] S_TO = 32'h1 << rcs_pkg::STAT_TO_BIT;
  localparam logic [31:0] S_PD = 32'h1 << rcs_pkg::STAT_PD_BIT;
  logic clk, rst_n, ovh, sleeping, pin, por_ok, bor_ok, wdt, core_rst_n, wake, pin_o, pin_oe_n, pu;
  logic lo, wk;
  logic slp, clr;
  rcs_pkg::rcs_axi_req_s req;
  rcs_pkg::rcs_axi_rsp_s rsp;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int t1, t2;
  logic [31:0] rd;
  logic [1:0] rr;

  rcs_sequencer #(.BOR_FILTER_CYC(8), .STARTUP_TICKS(4)) uut (.clk(clk), .rst_n(rst_n),
    .axi_req(req), .axi_rsp(rsp), .supply_above_por(por_ok), .supply_above_bor(bor_ok),
    .overheat_reset(ovh), .ext_rst_pin_i(pin), .ext_rst_pin_o(pin_o),
    .ext_rst_pin_oe_n(pin_oe_n), .ext_rst_pullup_en(pu), .watchdog_expire(wdt),
    .watchdog_clear_instruction(clr), .sleep_instruction(slp), .sleeping(sleeping),
    .core_rst_n(core_rst_n), .wake_pulse(wake));
  rcs_far_side far (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pullup_en(pu),
    .pin(pin), .por_ok(por_ok), .bor_ok(bor_ok), .wdt(wdt));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    // Whole run needs about 3400 cycles
    if (cyc == 20000)
    begin
      n_mismatch++;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (rsp.bvalid !== 1'b1);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rdr(input logic [11:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rdr(a);
    chk(rd, exp);
  endtask
  task automatic wait_run(output int k);
    k = 0;
    while (core_rst_n !== 1'b1 && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    chk({31'h0, k < 3000}, 32'h1);
  endtask
  task automatic watch;
    lo = 1'b0;
    wk = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      lo = lo | (core_rst_n === 1'b0);
      wk = wk | (wake === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rchk(A_PWR, 32'h1);
    rchk(A_ST, S_TO | S_PD);
    rchk(A_CFG, 32'h130);
    wr(A_PWR, 32'h3);
    rchk(A_PWR, 32'h3);
    wr(A_ST, 32'h0);
    chk({30'h0, rr}, {30'h0, rcs_pkg::RESP_SLVERR});
    rchk(12'h3fc, 32'h0);
    chk({30'h0, rr}, {30'h0, rcs_pkg::RESP_SLVERR});
  endtask
  task automatic t_wdt;
    far.expire();
    watch();
    chk({31'h0, lo}, 32'h1);
    chk({31'h0, pin_oe_n}, 32'h1);
    wait_run(t1);
    rchk(A_ST, S_PD);
  endtask
  task automatic t_wake;
    sleeping <= 1'b1;
    far.expire();
    watch();
    chk({31'h0, lo}, 32'h0);
    chk({31'h0, wk}, 32'h1);
    sleeping <= 1'b0;
    rchk(A_ST, 32'h0);
  endtask
  task automatic t_instr;
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    rchk(A_ST, S_TO);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    rchk(A_ST, S_TO | S_PD);
  endtask
  task automatic t_pin;
    far.pin_pulse(10);
    watch();
    chk({31'h0, lo}, 32'h0);
    sleeping <= 1'b1;
    far.pin_pulse(24);
    chk({31'h0, core_rst_n}, 32'h0);
    sleeping <= 1'b0;
    wait_run(t1);
    rchk(A_ST, S_TO);
    far.pin_pulse(24);
    chk({31'h0, core_rst_n}, 32'h0);
    wait_run(t1);
    rchk(A_ST, S_TO);
    wr(A_CFG, 32'h110);
    chk({31'h0, pu}, 32'h0);
    far.pin_pulse(24);
    chk({31'h0, core_rst_n}, 32'h1);
  endtask
  task automatic t_heat;
    ovh <= 1'b1;
    watch();
    chk({31'h0, lo}, 32'h1);
    ovh <= 1'b0;
    wait_run(t1);
  endtask
  task automatic t_bor;
    far.dip(1'b0, 5);
    watch();
    chk({31'h0, lo}, 32'h0);
    far.dip(1'b0, 40);
    chk({31'h0, core_rst_n}, 32'h0);
    wait_run(t1);
    rchk(A_PWR, 32'h2);
    rchk(A_ST, S_TO | S_PD);
    wr(A_PWR, 32'h3);
    wr(A_CFG, 32'h120);
  endtask
  task automatic t_por;
    far.dip(1'b1, 40);
    chk({31'h0, core_rst_n}, 32'h0);
    wait_run(t2);
    chk({31'h0, (t2 - t1 >= 12) && (t2 - t1 <= 20)}, 32'h1);
    rdr(A_PWR);
    chk(rd & 32'h2, 32'h0);
    rchk(A_ST, S_TO | S_PD);
    rchk(A_CFG, 32'h120);
  endtask

  initial
  begin
    rst_n = 1'b0;
    ovh = 1'b0;
    sleeping = 1'b0;
    slp = 1'b0;
    clr = 1'b0;
    req = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(t1);
    t_regs();
    t_wdt();
    t_wake();
    t_instr();
    t_pin();
    t_heat();
    t_bor();
    t_por();
    summarize();
  end
endmodule
